/* File: qbsd_pkg.sv */
package qbsd_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 12;
  localparam int ROWS = 4096;
  localparam int COLS_X4 = 2048;
  localparam int COLS_X8 = 1024;
  localparam int COLS_X16 = 1024;
  localparam int WIDTH_X4 = 4;
  localparam int WIDTH_X8 = 8;
  localparam int WIDTH_X16 = 16;
  localparam int MAX_COL_W = 11;
  localparam int AP_BIT = 10;
  localparam int COL_W_X4 = 11;
  localparam int COL_W_X8 = 10;
  localparam int COL_W_X16 = 10;
  // ----------------------------------------
  // burst length settings
  // ----------------------------------------
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam int PRECH_CYC = 2;
  localparam int READ_LAT_DEF = 2;

  typedef enum logic [2:0] {
    QBSD_NOP, QBSD_ACT, QBSD_RD, QBSD_WR, QBSD_PRE, QBSD_TERM
  } qbsd_cmd_t;

  typedef struct packed {
    qbsd_cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } qbsd_req_t;

  typedef struct packed {
    logic rd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [MAX_COL_W-1:0] col;
    logic [15:0] wdata;
  } qbsd_acc_t;
endpackage

/* File: qbsd_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module qbsd_mem
  import qbsd_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 16
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  // read data registered; no reset on array contents, like the real cells
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule // qbsd_mem
`default_nettype wire

/* File: qbsd_buf.sv */
`timescale 1ns/100ps
`default_nettype none
module qbsd_buf
  import qbsd_pkg::*;
#(
  parameter int DW = 16
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [DW-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [DW-1:0] out_data_out
);
  typedef struct packed {
    logic [1:0][DW-1:0] d;
    logic [1:0] cnt;
  } qbsd_bst_t;
  qbsd_bst_t s_r, s_nxt;
  logic push, pop;
  always_comb begin
    s_nxt = s_r;
    push = in_valid_in && (s_r.cnt != 2'h2);
    pop = out_ready_in && (s_r.cnt != 2'h0);
    if (pop) begin
      s_nxt.d[0] = s_r.d[1];
    end
    if (push) begin
      s_nxt.d[(pop ? s_r.cnt - 2'h1 : s_r.cnt) == 2'h0 ? 0 : 1] = in_data_in;
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // two entries so a stall never drops a word in flight
  assign in_ready_out = s_r.cnt != 2'h2;
  assign out_valid_out = s_r.cnt != 2'h0;
  assign out_data_out = s_r.d[0];
endmodule // qbsd_buf
`default_nettype wire

/* File: qbsd_core.sv */
// Notes on behaviour
// RULE1: all command, address and data inputs are sampled only on the rising clock edge.
// RULE2: four banks are tracked independently, each with its own open row and state.
// RULE3: an access opens a row with activate first; read or write to a closed bank is ignored.
// RULE4: activate latches the bank select lines and twelve address lines as the row.
// RULE5: read or write takes the address lines as the starting column in the open row.
// RULE6: the burst continues internally through the programmed number of columns in sequence.
// RULE7: burst lengths of one, two, four and eight are supported for reads and writes.
// RULE8: a full-page burst exists and any burst can be cut short by burst terminate.
// RULE9: with auto precharge the bank closes itself by a timed precharge at burst end; the code skips it for full-page and terminated bursts.
// RULE10: a new column command is accepted every cycle, restarting the burst; the code refuses it while the output buffer is full.
// RULE11: one bank may be precharged while another bank is accessed.
// RULE12: four-bit build: 4096 rows by 2048 columns of four bits per bank.
// RULE13: eight-bit build: 4096 rows by 1024 columns of eight bits per bank.
// RULE14: sixteen-bit build: 4096 rows by 1024 columns of sixteen bits per bank.
// RULE15: auto precharge is chosen per command by address line ten.
`timescale 1ns/100ps
`default_nettype none
module qbsd_core
  import qbsd_pkg::*;
#(
  parameter int DQ_W = WIDTH_X16,
  parameter int ROW_SIM_W = 4,
  parameter int READ_LAT = READ_LAT_DEF,
  parameter bit INTERLEAVE = 1'b0
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [2:0] BURST_LENGTH_SETTING_IN,
  input wire qbsd_req_t REQ_IN,
  output logic REQ_TAKEN_OUT,
  output logic RD_VALID_OUT,
  output logic [15:0] RD_DATA_OUT,
  input wire logic RD_READY_IN,
  output logic [BANKS-1:0] BANK_OPEN_OUT,
  output logic BURST_BUSY_OUT
);
  // ----------------------------------------
  // configuration
  // ----------------------------------------
  // column width follows data width (RULE12 RULE13 RULE14)
  localparam int COL_W = (DQ_W == WIDTH_X4) ? COL_W_X4 : COL_W_X8;
  // row bits kept in model storage are trimmed to keep the array small
  localparam int MEM_AW = BANK_W + ROW_SIM_W + COL_W;
  localparam logic [COL_W-1:0] COL_MAX = '1;

  initial begin
    if (DQ_W != WIDTH_X4 && DQ_W != WIDTH_X8 && DQ_W != WIDTH_X16) begin
      $error("qbsd_core: unsupported data width");
    end
    if (ROW_SIM_W < 1 || ROW_SIM_W > ADDR_W) begin
      $error("qbsd_core: bad row storage width");
    end
    if (READ_LAT < 1 || READ_LAT > 3) begin
      $error("qbsd_core: bad read latency");
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    QBSD_IDLE, QBSD_OPEN, QBSD_PRECH
  } qbsd_bank_t;

  typedef enum logic [1:0] {
    QBSD_BSTOP, QBSD_BREAD, QBSD_BWRITE
  } qbsd_burst_t;

  typedef struct packed {
    qbsd_bank_t [BANKS-1:0] bst;
    logic [BANKS-1:0][ADDR_W-1:0] row;
    logic [BANKS-1:0][1:0] pcnt;
    qbsd_burst_t burst;
    logic [BANK_W-1:0] bbank;
    logic [COL_W-1:0] start;
    logic [COL_W-1:0] idx;
    logic [COL_W-1:0] left;
    logic ap;
    logic [2:0] rpipe;
    logic taken;
    logic [BANKS-1:0] open;
    logic busy;
  } qbsd_st_t;

  qbsd_st_t s_r, s_nxt;
  logic [COL_W-1:0] blen_m1;
  logic [COL_W-1:0] cur_col;
  logic mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [15:0] mem_rdata;
  logic [DQ_W-1:0] mem_q;
  logic buf_ready;
  logic buf_valid;
  logic [15:0] buf_data;
  logic ap_now;
  logic burst_last;
  logic [BANK_W-1:0] cb;
  logic rd_stall;

  // ----------------------------------------
  // burst length decode
  // ----------------------------------------
  always_comb begin
    unique case (BURST_LENGTH_SETTING_IN) // RULE7
      BL_1: blen_m1 = COL_W'(0);
      BL_2: blen_m1 = COL_W'(1);
      BL_4: blen_m1 = COL_W'(3);
      BL_8: blen_m1 = COL_W'(7);
      BL_PAGE: blen_m1 = COL_MAX; // RULE8
      default: blen_m1 = COL_W'(0);
    endcase
  end

  // next column: wrap inside the aligned block, sequential or interleaved
  always_comb begin
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] eidx;
    mask = blen_m1;
    // a stalled read re-reads the word still waiting in the memory register
    eidx = (rd_stall && s_r.burst == QBSD_BREAD) ? s_r.idx - COL_W'(1) : s_r.idx;
    if (INTERLEAVE) begin
      cur_col = (s_r.start & ~mask) | ((s_r.start ^ eidx) & mask); // RULE6
    end else begin
      cur_col = (s_r.start & ~mask) | ((s_r.start + eidx) & mask); // RULE6
    end
  end

  assign ap_now = REQ_IN.addr[AP_BIT]; // RULE15
  assign cb = REQ_IN.bank;
  assign burst_last = (s_r.burst != QBSD_BSTOP) && (s_r.left == '0);
  // stall only while a fetched word waits for room, not merely on a full buffer
  assign rd_stall = s_r.rpipe[0] && !buf_ready;

  // ----------------------------------------
  // command decode and bank tracking
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.taken = 1'b0;
    // reads stall while a fetched word meets a full output buffer, so no word is lost
    if (rd_stall) begin
      s_nxt.rpipe = s_r.rpipe;
    end else begin
      s_nxt.rpipe = {s_r.rpipe[1:0], s_r.burst == QBSD_BREAD};
    end
    // per-bank precharge timers run independently (RULE2 RULE11)
    for (int b = 0; b < BANKS; b++) begin
      if (s_r.bst[b] == QBSD_PRECH) begin
        if (s_r.pcnt[b] == 2'h0) begin
          s_nxt.bst[b] = QBSD_IDLE; // RULE11
        end else begin
          s_nxt.pcnt[b] = s_r.pcnt[b] - 2'h1;
        end
      end
    end
    // burst sequencing
    if (s_r.burst != QBSD_BSTOP && !(s_r.burst == QBSD_BREAD && rd_stall)) begin
      if (burst_last) begin
        s_nxt.burst = QBSD_BSTOP;
        if (s_r.ap) begin
          s_nxt.bst[s_r.bbank] = QBSD_PRECH; // RULE9
          s_nxt.pcnt[s_r.bbank] = 2'(PRECH_CYC - 1);
        end
      end else begin
        s_nxt.idx = s_r.idx + COL_W'(1); // RULE6
        s_nxt.left = s_r.left - COL_W'(1);
      end
    end
    // commands sampled on the rising edge (RULE1)
    unique case (REQ_IN.cmd)
      QBSD_ACT: begin
        if (s_r.bst[cb] == QBSD_IDLE) begin
          s_nxt.bst[cb] = QBSD_OPEN; // RULE3
          s_nxt.row[cb] = REQ_IN.addr; // RULE4
          s_nxt.taken = 1'b1;
        end
      end
      QBSD_RD, QBSD_WR: begin
        if (s_r.bst[cb] == QBSD_OPEN && buf_ready) begin // RULE3
          s_nxt.burst = (REQ_IN.cmd == QBSD_RD) ? QBSD_BREAD : QBSD_BWRITE;
          s_nxt.bbank = cb;
          s_nxt.start = REQ_IN.addr[COL_W-1:0]; // RULE5
          s_nxt.idx = (REQ_IN.cmd == QBSD_WR) ? COL_W'(1) : '0; // RULE10
          s_nxt.left = (REQ_IN.cmd == QBSD_WR) ? blen_m1 - COL_W'(1) : blen_m1;
          s_nxt.ap = ap_now && (BURST_LENGTH_SETTING_IN != BL_PAGE);
          s_nxt.taken = 1'b1;
          // single write finishes in the command cycle itself
          if (REQ_IN.cmd == QBSD_WR && blen_m1 == '0) begin
            s_nxt.burst = QBSD_BSTOP;
            if (ap_now) begin
              s_nxt.bst[cb] = QBSD_PRECH; // RULE9
              s_nxt.pcnt[cb] = 2'(PRECH_CYC - 1);
            end
          end
        end
      end
      QBSD_PRE: begin
        if (s_r.bst[cb] == QBSD_OPEN && !(s_r.burst != QBSD_BSTOP && s_r.bbank == cb)) begin
          s_nxt.bst[cb] = QBSD_PRECH; // RULE11
          s_nxt.pcnt[cb] = 2'(PRECH_CYC - 1);
          s_nxt.taken = 1'b1;
        end
      end
      QBSD_TERM: begin
        s_nxt.burst = QBSD_BSTOP; // RULE8
        // keep the index on the last fetched word so a stalled tail is not lost
        s_nxt.idx = (rd_stall && s_r.burst == QBSD_BREAD) ? s_r.idx - COL_W'(1) : s_r.idx;
        s_nxt.taken = 1'b1;
      end
      QBSD_NOP: begin
      end
      default: begin
      end
    endcase
    for (int b = 0; b < BANKS; b++) begin
      s_nxt.open[b] = s_nxt.bst[b] == QBSD_OPEN;
    end
    s_nxt.busy = s_nxt.burst != QBSD_BSTOP;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // storage access
  // ----------------------------------------
  always_comb begin
    mem_we = 1'b0;
    mem_addr = {s_r.bbank, s_r.row[s_r.bbank][ROW_SIM_W-1:0], cur_col};
    if ((REQ_IN.cmd == QBSD_WR) && s_nxt.taken) begin
      mem_we = 1'b1;
      mem_addr = {cb, s_r.row[cb][ROW_SIM_W-1:0], REQ_IN.addr[COL_W-1:0]}; // RULE5
    end else if (s_r.burst == QBSD_BWRITE) begin
      mem_we = 1'b1; // RULE6
    end
  end

  qbsd_mem #(
    .AW(MEM_AW),
    .DW(DQ_W)
  ) u_mem (
    .clk_in(CLK_IN),
    .we_in(mem_we),
    .addr_in(mem_addr),
    .wdata_in(REQ_IN.wdata[DQ_W-1:0]),
    .rdata_out(mem_q)
  );

  assign mem_rdata = 16'(mem_q);

  qbsd_buf #(
    .DW(16)
  ) u_buf (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .in_valid_in(s_r.rpipe[0]),
    .in_ready_out(buf_ready),
    .in_data_in(mem_rdata),
    .out_valid_out(buf_valid),
    .out_ready_in(RD_READY_IN),
    .out_data_out(buf_data)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign REQ_TAKEN_OUT = s_r.taken;
  assign BANK_OPEN_OUT = s_r.open;
  assign BURST_BUSY_OUT = s_r.busy;
  assign RD_VALID_OUT = buf_valid;
  assign RD_DATA_OUT = buf_data;
endmodule // qbsd_core
`default_nettype wire

/* File: qbsd_core_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module qbsd_core_properties
  import qbsd_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire qbsd_req_t REQ_IN,
  input wire logic REQ_TAKEN_OUT,
  input wire logic RD_VALID_OUT,
  input wire logic [15:0] RD_DATA_OUT,
  input wire logic RD_READY_IN,
  input wire logic [BANKS-1:0] BANK_OPEN_OUT,
  input wire logic BURST_BUSY_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  qbsd_cmd_t cmd_q_r;
  logic [1:0] bank_q_r;
  logic [1:0] pre_b_r;
  // ----------------------------------------
  // last command seen, to tie the taken pulse to it
  // ----------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cmd_q_r <= QBSD_NOP;
      bank_q_r <= 2'h0;
      pre_b_r <= 2'h0;
    end else begin
      cmd_q_r <= REQ_IN.cmd;
      bank_q_r <= REQ_IN.bank;
      if (REQ_IN.cmd == QBSD_PRE) pre_b_r <= REQ_IN.bank;
    end
  end
  sequence rd_taken;
    cmd_q_r == QBSD_RD && REQ_TAKEN_OUT;
  endsequence
  sequence pre_taken;
    cmd_q_r == QBSD_PRE && REQ_TAKEN_OUT;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  reset_quiet_a: assert property (disable iff (1'b0)
    !RST_B_IN |-> !REQ_TAKEN_OUT && !RD_VALID_OUT && !BURST_BUSY_OUT && BANK_OPEN_OUT == '0)
    else $error("outputs active in reset");
  act_opens_a: assert property (cmd_q_r == QBSD_ACT && REQ_TAKEN_OUT |-> BANK_OPEN_OUT[bank_q_r])
    else $error("activate did not open bank");
  rd_closed_a: assert property (
    REQ_IN.cmd == QBSD_RD && !BANK_OPEN_OUT[REQ_IN.bank] |=> !REQ_TAKEN_OUT)
    else $error("read to closed bank taken");
  term_taken_a: assert property (REQ_IN.cmd == QBSD_TERM |=> REQ_TAKEN_OUT)
    else $error("terminate not taken");
  nop_quiet_a: assert property (REQ_IN.cmd == QBSD_NOP |=> !REQ_TAKEN_OUT)
    else $error("idle cycle taken");
  valid_hold_a: assert property (
    RD_VALID_OUT && !RD_READY_IN |=> RD_VALID_OUT && $stable(RD_DATA_OUT))
    else $error("stalled word lost");
  term_stop_a: assert property (REQ_IN.cmd == QBSD_TERM |-> ##[1:3] !BURST_BUSY_OUT)
    else $error("burst not stopped");
  pre_close_a: assert property (pre_taken |-> ##[0:2] !BANK_OPEN_OUT[pre_b_r])
    else $error("precharge did not close bank");
  rd_busy_a: assert property (rd_taken |-> BURST_BUSY_OUT)
    else $error("read burst not started");
endmodule // qbsd_core_properties
bind qbsd_core qbsd_core_properties chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .REQ_IN(REQ_IN),
  .REQ_TAKEN_OUT(REQ_TAKEN_OUT), .RD_VALID_OUT(RD_VALID_OUT), .RD_DATA_OUT(RD_DATA_OUT),
  .RD_READY_IN(RD_READY_IN), .BANK_OPEN_OUT(BANK_OPEN_OUT), .BURST_BUSY_OUT(BURST_BUSY_OUT));
`default_nettype wire

/* File: qbsd_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module qbsd_ctl_model
  import qbsd_pkg::*;
(
  input wire logic clk_in,
  input wire logic stall_in,
  output var qbsd_req_t req_out,
  output var logic rd_ready_out
);
  logic ph_r = 1'b0;
  initial req_out = '{QBSD_NOP, 2'h0, 12'h0, 16'h0};
  initial rd_ready_out = 1'b1;
  // ----------------------------------------
  // consumer, half rate when stalling so the buffer fills
  // ----------------------------------------
  always @(posedge clk_in) begin
    ph_r <= ~ph_r;
    rd_ready_out <= #1 !(stall_in && !ph_r);
  end
  // launched just after the edge, held a full cycle so it is sampled once
  task automatic drive(input qbsd_cmd_t c, input logic [1:0] b, input logic [11:0] a,
    input logic [15:0] d);
    @(posedge clk_in);
    #1 req_out = '{c, b, a, d};
  endtask
endmodule // qbsd_ctl_model
`default_nettype wire

/* File: quad_bank_sdram_core_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module quad_bank_sdram_core_tb
  import qbsd_pkg::*;
;
  typedef struct {logic [2:0] code; int bl; logic [1:0] b; logic [3:0] r; int c;} qbsd_row_t;
  qbsd_row_t rows[4] = '{'{BL_1, 1, 2'h0, 4'h1, 5}, '{BL_2, 2, 2'h1, 4'h2, 3},
    '{BL_4, 4, 2'h2, 4'h3, 6}, '{BL_8, 8, 2'h3, 4'h4, 13}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] bl_set = BL_1;
  logic stall = 1'b0;
  qbsd_req_t req;
  logic rd_ready, taken, rd_valid, busy;
  logic [15:0] rd_data;
  logic [3:0] open_b;
  logic [15:0] got[$];
  logic [15:0] exp[$];
  int n_mismatch = 0;
  int n_compared = 0;
  initial forever #4 clk = ~clk;
  qbsd_core dut (.CLK_IN(clk), .RST_B_IN(rst_b), .BURST_LENGTH_SETTING_IN(bl_set),
    .REQ_IN(req), .REQ_TAKEN_OUT(taken), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data),
    .RD_READY_IN(rd_ready), .BANK_OPEN_OUT(open_b), .BURST_BUSY_OUT(busy));
  qbsd_ctl_model ctl (.clk_in(clk), .stall_in(stall), .req_out(req), .rd_ready_out(rd_ready));
  always @(posedge clk) if (rd_valid && rd_ready) got.push_back(rd_data);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] pat(input logic [1:0] b, input logic [3:0] r, input int c);
    return {b, r, c[9:0]};
  endfunction
  function automatic int wcol(input int s, input int bl, input int j);
    return (s & ~(bl - 1)) | ((s + j) & (bl - 1));
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic go(input qbsd_cmd_t c, input logic [1:0] b, input int a, input int d);
    ctl.drive(c, b, a[11:0], d[15:0]);
  endtask
  task automatic settle(input int b);
    for (int k = 0; k < 40 && (busy !== 1'b0 || (b >= 0 && open_b[b] !== 1'b0)); k++)
      @(posedge clk);
    #1;
  endtask
  // extra cycles after the count is reached catch surplus words
  task automatic take();
    int n;
    n = exp.size();
    for (int k = 0; k < 60 && got.size() < n; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("word count", n, got.size());
    while (exp.size() > 0 && got.size() > 0) chk("read word", exp.pop_front(), got.pop_front());
    exp.delete();
    got.delete();
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int s, n;
    repeat (8) @(posedge clk);
    chk("reset outputs", 0, {taken, rd_valid, busy, open_b});
    #1 rst_b = 1'b1;
    foreach (rows[i]) begin
      bl_set = rows[i].code;
      stall = i[0];
      go(QBSD_ACT, rows[i].b, rows[i].r, 0);
      go(QBSD_NOP, 2'h0, 0, 0);
      chk("act taken", 1, taken);
      chk("bank open", 1, open_b[rows[i].b]);
      for (int j = 0; j < rows[i].bl; j++)
        go(j == 0 ? QBSD_WR : QBSD_NOP, rows[i].b, rows[i].c,
          pat(rows[i].b, rows[i].r, wcol(rows[i].c, rows[i].bl, j)));
      go(QBSD_NOP, 2'h0, 0, 0);
      settle(-1);
      s = wcol(rows[i].c, rows[i].bl, 1);
      for (int j = 0; j < rows[i].bl; j++)
        exp.push_back(pat(rows[i].b, rows[i].r, wcol(s, rows[i].bl, j)));
      go(QBSD_RD, rows[i].b, 'h400 | s, 0);
      go(QBSD_NOP, 2'h0, 0, 0);
      take();
      settle(rows[i].b);
      chk("auto close", 0, open_b[rows[i].b]);
    end
    go(QBSD_RD, 2'h0, 5, 0);
    go(QBSD_NOP, 2'h0, 0, 0);
    chk("closed read taken", 0, taken);
    take();
    bl_set = BL_1;
    stall = 1'b0;
    go(QBSD_ACT, 2'h0, 1, 0);
    go(QBSD_ACT, 2'h1, 2, 0);
    go(QBSD_NOP, 2'h0, 0, 0);
    chk("two banks open", 3, open_b[1:0]);
    go(QBSD_RD, 2'h1, 3, 0);
    go(QBSD_RD, 2'h0, 5, 0);
    go(QBSD_RD, 2'h1, 2, 0);
    go(QBSD_RD, 2'h1, 3, 0);
    go(QBSD_PRE, 2'h0, 0, 0);
    go(QBSD_NOP, 2'h0, 0, 0);
    chk("pre taken", 1, taken);
    exp = '{pat(2'h1, 4'h2, 3), pat(2'h0, 4'h1, 5), pat(2'h1, 4'h2, 2), pat(2'h1, 4'h2, 3)};
    settle(0);
    chk("bank one kept", 2, open_b[1:0]);
    take();
    bl_set = BL_PAGE;
    stall = 1'b1;
    for (int j = 0; j < 8; j++)
      go(j == 0 ? QBSD_WR : QBSD_NOP, 2'h1, 8, pat(2'h1, 4'h2, 8 + j));
    go(QBSD_TERM, 2'h0, 0, 0);
    go(QBSD_NOP, 2'h0, 0, 0);
    settle(-1);
    chk("write stopped", 0, busy);
    go(QBSD_RD, 2'h1, 'h408, 0);
    go(QBSD_NOP, 2'h0, 0, 0);
    go(QBSD_NOP, 2'h0, 0, 0);
    go(QBSD_TERM, 2'h0, 0, 0);
    go(QBSD_NOP, 2'h0, 0, 0);
    repeat (12) @(posedge clk);
    n = got.size();
    chk("page words in range", 1, n >= 1 && n <= 8);
    for (int j = 0; j < n; j++) chk("page word", pat(2'h1, 4'h2, 8 + j), got[j]);
    got.delete();
    chk("page keeps row", 1, open_b[1]);
    #1 rst_b = 1'b0;
    @(posedge clk);
    #1 chk("mid reset outputs", 0, {taken, rd_valid, busy, open_b});
    rst_b = 1'b1;
    wrap_up();
  end
endmodule // quad_bank_sdram_core_tb
`default_nettype wire
